// ==== hw/mbr_map.svh ====
// constants for the holding-register store and its request link
// assumes inclusion by bare name from the package and both link ends
`ifndef MBR_MAP_SVH
`define MBR_MAP_SVH

// store size and request limits
`define MBR_NUM_REGS     512
`define MBR_MAX_CNT      8'h2D
`define MBR_FIRST_REG    16'h0001
`define MBR_LAST_REG     17'h00200

// function codes on the link
`define MBR_FC_RD_HOLD   8'h03
`define MBR_FC_WR_SINGLE 8'h06
`define MBR_FC_WR_MULTI  8'h10
`define MBR_FC_RW_MULTI  8'h17

// exception codes
`define MBR_EXC_FUNC     8'h01
`define MBR_EXC_ADDR     8'h02

// zone accumulation input assembly, one-based start and length
`define MBR_ASM_START    16'h05DC
`define MBR_ASM_LEN      8'h15

// hand-off register (zero-based index) and its go value
`define MBR_HANDOFF_IDX  9'h020
`define MBR_HANDOFF_VAL  16'h0001

`endif

// ==== hw/mbr_pkg.sv ====
// types shared by the two link ends
// assumes mbr_map.svh is on the include path
`include "mbr_map.svh"

package mbr_pkg;

  // device end states
  typedef enum logic [3:0] {
    MBR_D_IDLE = 4'b0001,
    MBR_D_WR   = 4'b0010,
    MBR_D_RD   = 4'b0100,
    MBR_D_FIN  = 4'b1000
  } mbr_dev_state_t;

  // client end states
  typedef enum logic [2:0] {
    MBR_C_IDLE = 3'b001,
    MBR_C_REQ  = 3'b010,
    MBR_C_BUSY = 3'b100
  } mbr_cli_state_t;

endpackage

// ==== hw/mbr_link_if.sv ====
// byte-serial request link between client end and register store end
// assumes both ends share one clock; the testbench instantiates it
`timescale 1ns/1ps
`default_nettype none

interface mbr_link_if;
  logic       req_valid;
  logic       req_ready;
  logic [7:0] req_fc;
  logic [15:0] req_addr;
  logic [7:0] req_cnt;
  logic       wr_valid;
  logic       wr_ready;
  logic [7:0] wr_byte;
  logic       rsp_valid;
  logic [7:0] rsp_byte;
  logic       rsp_last;
  logic       rsp_err;

  modport device (
    input  req_valid, req_fc, req_addr, req_cnt, wr_valid, wr_byte,
    output req_ready, wr_ready, rsp_valid, rsp_byte, rsp_last, rsp_err
  );

  modport client (
    output req_valid, req_fc, req_addr, req_cnt, wr_valid, wr_byte,
    input  req_ready, wr_ready, rsp_valid, rsp_byte, rsp_last, rsp_err
  );
endinterface

`default_nettype wire

// ==== hw/mbr_client_end.sv ====
// client end: turns word commands into byte-serial link requests
// assumes the device end answers on the same clock and never stalls reads
`timescale 1ns/1ps
`default_nettype none
`include "mbr_map.svh"

module mbr_client_end (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  mbr_link_if.client       link,
  input  wire logic        cmd_valid_i,
  input  wire logic [7:0]  cmd_fc_i,
  input  wire logic [15:0] cmd_addr_i,
  input  wire logic [7:0]  cmd_cnt_i,
  input  wire logic        cmd_zero_based_i,
  output logic             cmd_ready_o,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wdata_valid_i,
  output logic             wdata_ready_o,
  output logic [15:0]      rdata_o,
  output logic             rdata_valid_o,
  output logic             done_o,
  output logic             err_o,
  output logic [7:0]       exc_o
);
  import mbr_pkg::*;

  mbr_cli_state_t state;
  logic           is_wr;
  logic           is_rd;
  logic           wphase;
  logic           rphase;
  logic [7:0]     wlo;
  logic [7:0]     rhi;

  // ==========================================================
  // command, request and response sequencing
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state           <= MBR_C_IDLE;
      cmd_ready_o     <= 1'b1;
      link.req_valid  <= 1'b0;
      link.req_fc     <= 8'h00;
      link.req_addr   <= 16'h0000;
      link.req_cnt    <= 8'h00;
      is_wr           <= 1'b0;
      is_rd           <= 1'b0;
      done_o          <= 1'b0;
      err_o           <= 1'b0;
      exc_o           <= 8'h00;
      rdata_o         <= 16'h0000;
      rdata_valid_o   <= 1'b0;
      rphase          <= 1'b0;
      rhi             <= 8'h00;
    end
    else
    begin
      done_o        <= 1'b0;
      rdata_valid_o <= 1'b0;
      case (state)
        MBR_C_IDLE:
        begin
          if (cmd_valid_i && cmd_ready_o)
          begin
            cmd_ready_o    <= 1'b0;
            link.req_valid <= 1'b1;
            link.req_fc    <= cmd_fc_i;
            // zero-based callers are shifted onto one-based numbering
            link.req_addr  <= cmd_addr_i + {15'h0000, cmd_zero_based_i};
            link.req_cnt   <= cmd_fc_i == `MBR_FC_WR_SINGLE ? 8'h01 : cmd_cnt_i;
            is_wr          <= cmd_fc_i == `MBR_FC_WR_SINGLE || cmd_fc_i == `MBR_FC_WR_MULTI
                              || cmd_fc_i == `MBR_FC_RW_MULTI;
            is_rd          <= cmd_fc_i == `MBR_FC_RD_HOLD || cmd_fc_i == `MBR_FC_RW_MULTI;
            err_o          <= 1'b0;
            rphase         <= 1'b0;
            state          <= MBR_C_REQ;
          end
        end
        MBR_C_REQ:
        begin
          if (link.req_ready)
          begin
            link.req_valid <= 1'b0;
            state          <= MBR_C_BUSY;
          end
        end
        MBR_C_BUSY:
        begin
          if (link.rsp_valid)
          begin
            if (link.rsp_err)
            begin
              err_o <= 1'b1;
              exc_o <= link.rsp_byte;
            end
            else if (is_rd)
            begin
              // high byte arrives first
              rphase <= ~rphase;
              rhi    <= link.rsp_byte;
              if (rphase)
              begin
                rdata_o       <= {rhi, link.rsp_byte};
                rdata_valid_o <= 1'b1;
              end
            end
            if (link.rsp_last)
            begin
              done_o      <= 1'b1;
              cmd_ready_o <= 1'b1;
              state       <= MBR_C_IDLE;
            end
          end
        end
        default:
        begin
          state       <= MBR_C_IDLE;
          cmd_ready_o <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // write data: each word leaves high byte first
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wdata_ready_o <= 1'b0;
      link.wr_valid <= 1'b0;
      link.wr_byte  <= 8'h00;
      wphase        <= 1'b0;
      wlo           <= 8'h00;
    end
    else if (state != MBR_C_BUSY || !is_wr || (link.rsp_valid && link.rsp_last))
    begin
      wdata_ready_o <= 1'b0;
      link.wr_valid <= 1'b0;
      wphase        <= 1'b0;
    end
    // ask for the first word only once the store end opens write data;
    // a refused write never opens it, so no caller word is swallowed
    else if (!link.wr_valid && !wdata_ready_o && !wphase)
    begin
      wdata_ready_o <= link.wr_ready;
    end
    else if (wdata_valid_i && wdata_ready_o)
    begin
      wdata_ready_o <= 1'b0;
      link.wr_valid <= 1'b1;
      link.wr_byte  <= wdata_i[15:8];
      wlo           <= wdata_i[7:0];
      wphase        <= 1'b0;
    end
    else if (link.wr_valid && link.wr_ready)
    begin
      if (!wphase)
      begin
        link.wr_byte <= wlo;
        wphase       <= 1'b1;
      end
      else
      begin
        link.wr_valid <= 1'b0;
        wdata_ready_o <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ==== hw/mbr_device_end.sv ====
// register store end: 512 holding registers, request decoding,
// assembly gathering and byte-serial answers on the link
// assumes a client end on the same clock that sinks one byte per cycle
`timescale 1ns/1ps
`default_nettype none
`include "mbr_map.svh"

module mbr_device_end #(
  parameter int NUM_REGS = `MBR_NUM_REGS
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  mbr_link_if.device       link,
  input  wire logic        local_we_i,
  input  wire logic [8:0]  local_addr_i,
  input  wire logic [15:0] local_wdata_i,
  output logic [15:0]      local_rdata_o,
  output logic             handoff_seen_o
);
  import mbr_pkg::*;

  // ==========================================================
  // storage
  logic [15:0]    mem [NUM_REGS];

  mbr_dev_state_t state;
  logic [7:0]     fc;
  logic [7:0]     cnt;
  logic [7:0]     k;
  logic [8:0]     base;
  logic           asm_sel;
  logic           phase;
  logic [7:0]     hold;

  // request checks, evaluated on the request as it stands on the link
  logic           fc_ok;
  logic           wr_req;
  logic [7:0]     cnt_eff;
  logic           cnt_ok;
  logic [16:0]    end_addr;
  logic           phys_ok;
  logic           asm_ok;
  logic           req_fire;
  logic           wr_fire;
  logic [8:0]     rd_idx;
  logic [15:0]    rd_word;

  // ==========================================================
  // assembly member table: zone accumulation inputs in image order
  function automatic logic [8:0] asm_member(input logic [4:0] n);
    logic [8:0] r;
    r = 9'h000;
    case (n)
      5'h00:   r = 9'h073;
      5'h01:   r = 9'h0C3;
      5'h02:   r = 9'h069;
      5'h03:   r = 9'h06A;
      5'h04:   r = 9'h0B9;
      5'h05:   r = 9'h0BA;
      5'h06:   r = 9'h040;
      5'h07:   r = 9'h041;
      5'h08:   r = 9'h042;
      5'h09:   r = 9'h06C;
      5'h0A:   r = 9'h06D;
      5'h0B:   r = 9'h0BC;
      5'h0C:   r = 9'h0BD;
      5'h0D:   r = 9'h074;
      5'h0E:   r = 9'h0C4;
      5'h0F:   r = 9'h075;
      5'h10:   r = 9'h0C5;
      5'h11:   r = 9'h100;
      5'h12:   r = 9'h101;
      5'h13:   r = 9'h102;
      5'h14:   r = 9'h103;
      default: r = 9'h000;
    endcase
    return r;
  endfunction

  // ==========================================================
  // request decoding
  assign req_fire = link.req_valid && link.req_ready;
  assign wr_fire  = link.wr_valid && link.wr_ready;
  assign fc_ok    = link.req_fc == `MBR_FC_RD_HOLD || link.req_fc == `MBR_FC_WR_SINGLE
                    || link.req_fc == `MBR_FC_WR_MULTI || link.req_fc == `MBR_FC_RW_MULTI;
  assign wr_req   = link.req_fc != `MBR_FC_RD_HOLD;
  // a single write always moves exactly one register
  assign cnt_eff  = link.req_fc == `MBR_FC_WR_SINGLE ? 8'h01 : link.req_cnt;
  assign cnt_ok   = cnt_eff != 8'h00 && cnt_eff <= `MBR_MAX_CNT;
  assign end_addr = {1'b0, link.req_addr} + {9'h000, cnt_eff} - 17'h00001;
  // register zero does not exist, the store ends at the last register
  assign phys_ok  = link.req_addr >= `MBR_FIRST_REG && end_addr <= `MBR_LAST_REG;
  // only the first register opens the assembly; it is read-only here
  assign asm_ok   = link.req_addr == `MBR_ASM_START && cnt_eff <= `MBR_ASM_LEN
                    && !wr_req;

  // read pointer: straight run in the store, or gathered members
  assign rd_idx   = asm_sel ? asm_member(k[4:0]) : 9'(base + {1'b0, k});
  assign rd_word  = mem[rd_idx];

  // ==========================================================
  // sequencing and link answers
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state          <= MBR_D_IDLE;
      link.req_ready <= 1'b1;
      link.wr_ready  <= 1'b0;
      link.rsp_valid <= 1'b0;
      link.rsp_byte  <= 8'h00;
      link.rsp_last  <= 1'b0;
      link.rsp_err   <= 1'b0;
      fc             <= 8'h00;
      cnt            <= 8'h00;
      k              <= 8'h00;
      base           <= 9'h000;
      asm_sel        <= 1'b0;
      phase          <= 1'b0;
      hold           <= 8'h00;
    end
    else
    begin
      case (state)
        MBR_D_IDLE:
        begin
          if (req_fire)
          begin
            link.req_ready <= 1'b0;
            fc             <= link.req_fc;
            cnt            <= cnt_eff;
            k              <= 8'h00;
            phase          <= 1'b0;
            base           <= 9'(link.req_addr - `MBR_FIRST_REG);
            asm_sel        <= asm_ok;
            if (!fc_ok || !cnt_ok || !(phys_ok || asm_ok))
            begin
              // refused before any write data is asked for
              link.rsp_valid <= 1'b1;
              link.rsp_err   <= 1'b1;
              link.rsp_last  <= 1'b1;
              link.rsp_byte  <= fc_ok ? `MBR_EXC_ADDR : `MBR_EXC_FUNC;
              state          <= MBR_D_FIN;
            end
            else if (wr_req)
            begin
              link.wr_ready <= 1'b1;
              state         <= MBR_D_WR;
            end
            else
            begin
              state <= MBR_D_RD;
            end
          end
        end
        MBR_D_WR:
        begin
          if (wr_fire)
          begin
            // first byte of a pair is the high byte
            phase <= ~phase;
            hold  <= link.wr_byte;
            if (phase)
            begin
              k <= k + 8'h01;
              if (k + 8'h01 == cnt)
              begin
                link.wr_ready <= 1'b0;
                if (fc == `MBR_FC_RW_MULTI)
                begin
                  k     <= 8'h00;
                  state <= MBR_D_RD;
                end
                else
                begin
                  link.rsp_valid <= 1'b1;
                  link.rsp_last  <= 1'b1;
                  link.rsp_byte  <= fc;
                  state          <= MBR_D_FIN;
                end
              end
            end
          end
        end
        MBR_D_RD:
        begin
          // one byte per cycle, high half of the word first
          link.rsp_valid <= 1'b1;
          link.rsp_byte  <= phase ? rd_word[7:0] : rd_word[15:8];
          link.rsp_last  <= phase && (k + 8'h01 == cnt);
          phase          <= ~phase;
          if (phase)
          begin
            k <= k + 8'h01;
            if (k + 8'h01 == cnt)
            begin
              state <= MBR_D_FIN;
            end
          end
        end
        MBR_D_FIN:
        begin
          link.rsp_valid <= 1'b0;
          link.rsp_last  <= 1'b0;
          link.rsp_err   <= 1'b0;
          link.req_ready <= 1'b1;
          state          <= MBR_D_IDLE;
        end
        default:
        begin
          link.req_ready <= 1'b1;
          state          <= MBR_D_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // store writes; the store keeps no reset so local data survives
  // link restarts, and a link write wins a same-index collision
  always_ff @(posedge sys_clk_i)
  begin
    if (local_we_i)
    begin
      mem[local_addr_i] <= local_wdata_i;
    end
    if (state == MBR_D_WR && wr_fire && phase)
    begin
      mem[9'(base + {1'b0, k})] <= {hold, link.wr_byte};
    end
  end

  // ==========================================================
  // local process read port, one cycle of latency
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      local_rdata_o <= 16'h0000;
    end
    else
    begin
      local_rdata_o <= mem[local_addr_i];
    end
  end

  // ==========================================================
  // hand-off watch: upstream neighbour writes the go value here
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      handoff_seen_o <= 1'b0;
    end
    else
    begin
      handoff_seen_o <= mem[`MBR_HANDOFF_IDX] == `MBR_HANDOFF_VAL;
    end
  end

endmodule

`default_nettype wire

// ==== verification/mbr_link_props.sv ====
// checker for the request link between client end and store end
// assumes one clock and an active-high async reset; sits beside the link
`timescale 1ns/1ps
`default_nettype none

module mbr_link_props (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [7:0]  req_fc,
  input wire logic [15:0] req_addr,
  input wire logic [7:0]  req_cnt,
  input wire logic        wr_valid,
  input wire logic        wr_ready,
  input wire logic [7:0]  wr_byte,
  input wire logic        rsp_valid,
  input wire logic [7:0]  rsp_byte,
  input wire logic        rsp_last,
  input wire logic        rsp_err
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // ====================
  // helpers
  logic        take;
  logic        fc_ok;
  logic        rd_ok;
  logic [7:0]  fc_q;
  logic [7:0]  cnt_q;
  logic [15:0] nb;
  assign take  = req_valid && req_ready;
  assign fc_ok = req_fc inside {8'h03, 8'h06, 8'h10, 8'h17};
  assign rd_ok = req_fc == 8'h03 && req_addr != 16'h0000 && req_cnt != 8'h00
                 && req_cnt <= 8'h2D && 17'(req_addr) + 17'(req_cnt) <= 17'h00201;
  // bytes answered since the last take; the read length is judged on it
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      nb    <= '0;
      fc_q  <= '0;
      cnt_q <= '0;
    end
    else if (take)
    begin
      nb    <= '0;
      fc_q  <= req_fc;
      cnt_q <= req_cnt;
    end
    else if (rsp_valid)
      nb <= nb + 16'h0001;
  end
  // ====================
  // assertions
  chk_take_busy: assert property (take |=> !req_ready)
    else $error("ready stayed high after a take");
  chk_rsp_busy: assert property (rsp_valid |-> !req_ready)
    else $error("answer byte while ready");
  chk_bad_func: assert property (take && !fc_ok |=> rsp_valid && rsp_err && rsp_last
    && rsp_byte == 8'h01) else $error("bad code not refused");
  chk_bad_count: assert property (take && fc_ok && req_fc != 8'h06
    && (req_cnt == 8'h00 || req_cnt > 8'h2D) |=> rsp_err && rsp_byte == 8'h02 && !wr_ready)
    else $error("bad count not refused");
  chk_addr_zero: assert property (take && fc_ok && req_addr == 16'h0000
    |=> rsp_valid && rsp_err && rsp_byte == 8'h02) else $error("address zero accepted");
  chk_asm_offset: assert property (take && fc_ok && req_addr inside {[16'h05DD:16'h05F0]}
    |=> (rsp_err && rsp_byte == 8'h02) ##1 !wr_ready [*3]) else $error("mid-group start taken");
  chk_asm_write: assert property (take && req_fc != 8'h03 && fc_ok
    && req_addr == 16'h05DC |=> rsp_err && !wr_ready) else $error("group write accepted");
  chk_read_lead: assert property (take && rd_ok |=> !rsp_valid ##1 rsp_valid && !rsp_err)
    else $error("read answer not two cycles after take");
  chk_read_len: assert property (rsp_valid && rsp_last && !rsp_err
    && fc_q inside {8'h03, 8'h17} |-> nb + 16'h0001 == {7'h00, cnt_q, 1'b0})
    else $error("read answer length wrong");
  chk_ack_code: assert property (rsp_valid && !rsp_err && fc_q inside {8'h06, 8'h10}
    |-> rsp_last && rsp_byte == fc_q) else $error("write ack wrong");
  chk_wr_window: assert property (wr_valid |-> wr_ready)
    else $error("write byte offered outside collection");
  chk_last_gap: assert property (rsp_valid && rsp_last |=> !rsp_valid ##[0:1] req_ready)
    else $error("link not free after last byte");
  cover property (take && req_fc == 8'h03 && req_addr == 16'h05DC);
  cover property (take && req_fc == 8'h17);
  cover property (rsp_valid && rsp_err);
endmodule

`default_nettype wire

// ==== verification/modbus_register_assembly_access_test.sv ====
// bench: client end and store end on one link, plus a raw-driven store end
// assumes the hw sources and mbr_map.svh are compiled first
`timescale 1ns/1ps
`default_nettype none

module modbus_register_assembly_access_test;
  // ====================
  // stimulus state and instances
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cmd_valid_i = 1'b0;
  logic        cmd_zero_based_i = 1'b0;
  logic        wdata_valid_i = 1'b0;
  logic        local_we_i = 1'b0;
  logic [7:0]  cmd_fc_i = '0;
  logic [7:0]  cmd_cnt_i = '0;
  logic [15:0] cmd_addr_i = '0;
  logic [15:0] wdata_i = '0;
  logic [15:0] local_wdata_i = '0;
  logic [8:0]  local_addr_i = '0;
  logic        cmd_ready_o, wdata_ready_o, rdata_valid_o, done_o, err_o, handoff_seen_o;
  logic [15:0] rdata_o, local_rdata_o;
  logic [7:0]  exc_o;
  logic [15:0] mdl [512];
  logic [15:0] wq [$], rq [$];
  logic [7:0]  rb [$], wb [$];
  int          fails = 0, n_checks = 0, seed = 57, i, j;
  localparam logic [8:0] ASM [21] = '{9'h073, 9'h0C3, 9'h069, 9'h06A, 9'h0B9, 9'h0BA, 9'h040,
    9'h041, 9'h042, 9'h06C, 9'h06D, 9'h0BC, 9'h0BD, 9'h074, 9'h0C4, 9'h075, 9'h0C5, 9'h100,
    9'h101, 9'h102, 9'h103};
  localparam logic [31:0] CASES [14] = '{32'h03000001, 32'h03020001, 32'h03020002,
    32'h0300012E, 32'h10000100, 32'h05000101, 32'h0305DC15, 32'h0305DC16, 32'h0305E005,
    32'h0605DC01, 32'h1700012D, 32'h1001D42D, 32'h0301D42D, 32'h03020101};
  localparam logic [39:0] RAW [4] = '{40'h0305E00502, 40'h1005DC0202, 40'h0300000102,
    40'h2B00010101};
  localparam logic [7:0] FCS [6] = '{8'h03, 8'h06, 8'h10, 8'h17, 8'h03, 8'h2B};
  mbr_link_if link ();
  mbr_link_if link2 ();
  mbr_client_end u_mbr_client_end (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link),
    .cmd_valid_i(cmd_valid_i), .cmd_fc_i(cmd_fc_i), .cmd_addr_i(cmd_addr_i),
    .cmd_cnt_i(cmd_cnt_i), .cmd_zero_based_i(cmd_zero_based_i), .cmd_ready_o(cmd_ready_o),
    .wdata_i(wdata_i), .wdata_valid_i(wdata_valid_i), .wdata_ready_o(wdata_ready_o),
    .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o), .done_o(done_o), .err_o(err_o),
    .exc_o(exc_o));
  mbr_device_end u_mbr_device_end (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link),
    .local_we_i(local_we_i), .local_addr_i(local_addr_i), .local_wdata_i(local_wdata_i),
    .local_rdata_o(local_rdata_o), .handoff_seen_o(handoff_seen_o));
  // second store end faces the raw driver that breaks the client rules
  mbr_device_end u_mbr_device_end_2 (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link2),
    .local_we_i(1'b0), .local_addr_i(9'h000), .local_wdata_i(16'h0000),
    .local_rdata_o(), .handoff_seen_o());
  mbr_link_props u_mbr_link_props (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .req_valid(link.req_valid), .req_ready(link.req_ready), .req_fc(link.req_fc),
    .req_addr(link.req_addr), .req_cnt(link.req_cnt), .wr_valid(link.wr_valid),
    .wr_ready(link.wr_ready), .wr_byte(link.wr_byte), .rsp_valid(link.rsp_valid),
    .rsp_byte(link.rsp_byte), .rsp_last(link.rsp_last), .rsp_err(link.rsp_err));

  always #25 sys_clk_i = ~sys_clk_i;
  // write words leave the queue only on a taken handshake
  always @(posedge sys_clk_i)
    if (wdata_valid_i && wdata_ready_o) void'(wq.pop_front());
  // present queued words and sample settled outputs away from the launching edge
  always @(negedge sys_clk_i)
  begin
    wdata_valid_i = wq.size() > 0;
    wdata_i = (wq.size() > 0) ? wq[0] : 16'h0000;
    if (rdata_valid_o === 1'b1) rq.push_back(rdata_o);
    if (link.rsp_valid === 1'b1) rb.push_back(link.rsp_byte);
    if (link.wr_valid === 1'b1 && link.wr_ready === 1'b1) wb.push_back(link.wr_byte);
  end
  // ====================
  // checking helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [7:0] exc_of(logic [7:0] f, logic [15:0] a, logic [7:0] n);
    if (!(f inside {8'h03, 8'h06, 8'h10, 8'h17})) return 8'h01;
    if (n == 8'h00 || n > 8'h2D || a == 16'h0000) return 8'h02;
    if (a == 16'h05DC) return (f == 8'h03 && n <= 8'h15) ? 8'h00 : 8'h02;
    if (17'(a) + 17'(n) > 17'h00201) return 8'h02;
    return 8'h00;
  endfunction
  function automatic logic [15:0] exp_rd(logic [15:0] a, int k);
    return (a == 16'h05DC) ? mdl[ASM[k]] : mdl[int'(a) - 1 + k];
  endfunction
  // one command through the client end, judged on its words and link bytes
  task automatic txn(input logic [31:0] cs, input logic zb, input logic fix,
                     input logic [15:0] w0);
    logic [7:0]  f, n, ex;
    logic [15:0] a, e;
    logic [15:0] w [$];
    int          k;
    f = cs[31:24];
    a = cs[23:8];
    n = (f == 8'h06) ? 8'h01 : cs[7:0];
    ex = exc_of(f, a, n);
    @(negedge sys_clk_i);
    rq.delete(); rb.delete(); wb.delete(); wq.delete();
    for (k = 0; k < n; k++) w.push_back(fix ? w0 : 16'($random(seed)));
    wq = w;
    cmd_valid_i = 1'b1;
    cmd_fc_i = f;
    cmd_addr_i = a - 16'(zb);
    cmd_cnt_i = cs[7:0];
    cmd_zero_based_i = zb;
    while (cmd_ready_o !== 1'b1) @(negedge sys_clk_i);
    @(negedge sys_clk_i);
    cmd_valid_i = 1'b0;
    for (k = 0; k < 3000 && done_o !== 1'b1; k++) @(negedge sys_clk_i);
    chk({15'h0, done_o}, 16'h0001);
    @(negedge sys_clk_i);
    chk({15'h0, err_o}, {15'h0, ex != 8'h00});
    if (ex != 8'h00)
    begin
      chk({8'h00, exc_o}, {8'h00, ex});
      chk({rb[0], 8'(rb.size())}, {ex, 8'h01});
      chk(16'(wb.size()), 16'h0000);
    end
    else
    begin
      chk(16'(rb.size()), (f == 8'h03 || f == 8'h17) ? 16'(2 * n) : 16'h0001);
      for (k = 0; k < n && f != 8'h03; k++)
      begin
        mdl[int'(a) - 1 + k] = w[k];
        chk({wb[2 * k], wb[2 * k + 1]}, w[k]);
      end
      for (k = 0; k < n && (f == 8'h03 || f == 8'h17); k++)
      begin
        e = exp_rd(a, k);
        chk(rq[k], e);
        chk({rb[2 * k], rb[2 * k + 1]}, e);
      end
      if (f == 8'h06 || f == 8'h10) chk({8'h00, rb[0]}, {8'h00, f});
    end
  endtask
  // raw request on the second link, as a client that ignores the rules
  task automatic raw(input logic [39:0] r);
    int k;
    @(negedge sys_clk_i);
    link2.req_valid = 1'b1;
    link2.req_fc = r[39:32];
    link2.req_addr = r[31:16];
    link2.req_cnt = r[15:8];
    while (link2.req_ready !== 1'b1) @(negedge sys_clk_i);
    @(negedge sys_clk_i);
    link2.req_valid = 1'b0;
    for (k = 0; k < 20 && link2.rsp_valid !== 1'b1; k++) @(negedge sys_clk_i);
    chk({8'h00, link2.rsp_byte}, {8'h00, r[7:0]});
    chk({14'h0, link2.rsp_err, link2.wr_ready}, 16'h0002);
    repeat (3) @(negedge sys_clk_i);
  endtask
  // ====================
  // main sequence
  initial
  begin
    link2.req_valid = 1'b0;
    link2.wr_valid = 1'b0;
    link2.wr_byte = 8'h00;
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_i = 1'b0;
    // fill the store locally so no read meets an unwritten word
    for (i = 0; i < 512; i++)
    begin
      @(negedge sys_clk_i);
      local_we_i = 1'b1;
      local_addr_i = 9'(i);
      local_wdata_i = 16'($random(seed));
      mdl[i] = local_wdata_i;
    end
    @(negedge sys_clk_i);
    local_we_i = 1'b0;
    for (i = 0; i < 14; i++) txn(CASES[i], 1'b0, 1'b0, 16'h0000);
    for (i = 0; i < 60; i++)
    begin
      j = 1 + ($random(seed) & 32'h1FF);
      txn({FCS[($random(seed) & 32'h7) % 6], 16'(j), 8'(1 + ($random(seed) & 32'hFF) % 45)},
          1'($random(seed)), 1'b0, 16'h0000);
    end
    // network writes must show on the local side
    for (i = 0; i < 8; i++)
    begin
      @(negedge sys_clk_i);
      // index zero was written over the link by the combined-code corner case
      local_addr_i = (i == 0) ? 9'h000 : 9'($random(seed) & 32'h1FF);
      @(negedge sys_clk_i);
      chk(local_rdata_o, mdl[local_addr_i]);
    end
    txn(32'h06002101, 1'b0, 1'b1, 16'h0001);
    chk({15'h0, handoff_seen_o}, 16'h0001);
    txn(32'h06002101, 1'b1, 1'b1, 16'h0000);
    chk({15'h0, handoff_seen_o}, 16'h0000);
    for (i = 0; i < 4; i++) raw(RAW[i]);
    stop_test();
  end
  // watchdog at 60000 clock cycles, several times the longest expected run
  initial
  begin
    #3000000;
    fails++;
    stop_test();
  end
endmodule

`default_nettype wire
